//--- src/icp_pkg.sv
// Shared constants and types for the configuration port with upper-space lock
package icp_pkg;

  // Link sampling clock and input glitch filter
  localparam int unsigned LINK_PERIOD_NS = 64;                 // Link sampling clock period
  localparam int unsigned GLITCH_NS      = 50;                 // Pulses shorter than this are ignored
  localparam int unsigned GLITCH_CYC     = (GLITCH_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam int unsigned FILT_W         = 2;                  // Filter counter width
  localparam logic [FILT_W-1:0] FILT_LIMIT = FILT_W'(GLITCH_CYC);

  // Target address
  localparam logic [4:0] ADDR_UPPER = 5'h1a;                   // Fixed upper five address bits

  // Register store geometry and reset content
  localparam int unsigned MEM_AW    = 8;                       // Register index width
  localparam int unsigned MEM_DW    = 16;                      // Register word width
  localparam int unsigned MEM_DEPTH = 256;                     // Number of registers
  localparam logic [MEM_DW-1:0] REG_RESET = 16'h0000;          // Value after the clearing sweep
  localparam logic [MEM_AW-1:0] MEM_LAST  = 8'hff;             // Last index of the sweep

  // Upper space lock
  localparam logic [MEM_AW-1:0] UNLOCK_REG  = 8'h0c;           // Register holding the key
  localparam logic [MEM_AW-1:0] UPPER_FIRST = 8'h0d;           // First fully protected register
  localparam logic [7:0]        UNLOCK_KEY  = 8'h5b;           // Key value in the lower byte

  // Read-only registers occupy indices 0 up to this one
  localparam logic [MEM_AW-1:0] RO_LAST = 8'h01;

  // Fuse store: per-page start-up words
  localparam logic [MEM_AW-1:0] FUSE_OUT_REG = 8'h07;          // Output format and enables
  localparam logic [MEM_AW-1:0] FUSE_SSC_REG = 8'h09;          // Spread enable and setup
  localparam logic [3:0][MEM_DW-1:0] FUSE_OUT_CFG = {16'h6103, 16'h6103, 16'h6103, 16'h6103};
  localparam logic [3:0][MEM_DW-1:0] FUSE_SSC_CFG = {16'h0003, 16'h0002, 16'h0001, 16'h0000};
  localparam logic [1:0] BUS_MODE_PAGE = 2'h0;                 // Page used in bus mode

  // Start-up strap settling wait, in core clock cycles
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  // Strap pin connection as reported by the pad sense logic
  typedef enum logic [1:0] {
    STRAP_GND,
    STRAP_VDD,
    STRAP_SDA,
    STRAP_SCL
  } icp_strap_t;

  // Register access request from link to core
  typedef struct packed {
    logic              we;
    logic [MEM_AW-1:0] addr;
    logic [MEM_DW-1:0] wdata;
  } icp_req_t;

  // Quasi-static status from core to link
  typedef struct packed {
    logic       enable;
    logic [1:0] lsbs;
  } icp_lstat_t;

  // Address bits chosen by the strap connection
  function automatic logic [1:0] strap_lsbs(input logic [1:0] code);
    case (icp_strap_t'(code))
      STRAP_GND: strap_lsbs = 2'h0;
      STRAP_VDD: strap_lsbs = 2'h1;
      STRAP_SDA: strap_lsbs = 2'h2;
      default:   strap_lsbs = 2'h3;
    endcase
  endfunction

  // Registers whose bits software cannot change
  function automatic logic is_read_only(input logic [MEM_AW-1:0] idx);
    is_read_only = (idx <= RO_LAST);
  endfunction

endpackage

//--- src/icp_regmem.sv
// Register store: single port memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module icp_regmem
  import icp_pkg::*;
(
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  // Access port
  input  wire logic              i_we,
  input  wire logic [MEM_AW-1:0] i_addr,
  input  wire logic [MEM_DW-1:0] i_wdata,
  output logic      [MEM_DW-1:0] o_rdata
);

  logic [MEM_DW-1:0] mem [MEM_DEPTH];  // Storage, cleared by the core sweep

  // Write port, no reset so it maps to block memory
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
  end

  // Read data register returns the old word on a write
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata <= REG_RESET;
    end else begin
      o_rdata <= mem[i_addr];
    end
  end

endmodule
`default_nettype wire

//--- src/icp_port.sv
// Serial configuration port: bus target, start-up load and upper-space lock
//
// Functional notes
// RQ1: Works at standard and fast bus rates.
// RQ2: Pulses under fifty nanoseconds are ignored.
// RQ3: Responds only when sent address matches.
// RQ4: Upper five bits fixed, strap sets two.
// RQ5: Data changes only while clock is low.
// RQ6: Start and stop bound every transfer.
// RQ7: Bytes are eight bits, MSB first, acknowledged.
// RQ8: Register index byte, then sixteen-bit word.
// RQ9: Receiver pulls data low on ninth clock.
// RQ10: Acknowledge match, else idle until start.
// RQ11: Controller stops after final write acknowledge.
// RQ12: Read not-acknowledge ends driving, goes idle.
// RQ13: Controller forms stop after read not-acknowledge.
// RQ14: Upper space writable only after key written.
// RQ15: Host unlocks before edge combiner changes.
// RQ16: Start-up loads six page-dependent fields.
// RQ17: Writes to read-only bits are ignored.
// RQ18: Reference pin picks bus or fuse mode.
// RQ19: Data line released except ack or read.
`timescale 1ns/1ps
`default_nettype none
module icp_port
  import icp_pkg::*;
(
  // Core clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Link sampling clock
  input  wire logic       i_link_clk,
  // Bus pins
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_o,
  output logic            o_sda_oe,
  // Start-up straps
  input  wire logic       i_ref_ctrl,
  input  wire logic [1:0] i_addr_strap,
  input  wire logic [1:0] i_fuse_page,
  // Status
  output logic            o_bus_mode,
  output logic            o_cfg_ready,
  output logic            o_unlocked,
  output logic [1:0]      o_fuse_page
);

  // ---------------- Core domain ----------------
  typedef enum {C_STRAP, C_CLEAR, C_FUSE_OUT, C_FUSE_SSC, C_RUN, C_APPLY} icp_cstate_t;

  icp_cstate_t       cst;           // Core sequencer state
  logic [4:0]        pin_s1;        // Strap synchroniser, first stage
  logic [4:0]        pin_s2;        // Strap synchroniser, second stage
  logic [1:0]        strap_cnt;     // Settling wait after reset
  logic              bus_mode;      // Bus-programmable mode
  logic [1:0]        own_lsbs;      // Strapped address bits
  logic [1:0]        page;          // Fuse page in use
  logic              unlocked;      // Upper space open
  logic [MEM_AW-1:0] clr_addr;      // Clearing sweep index
  logic              req_s1;        // Request toggle sync, first stage
  logic              req_s2;        // Request toggle sync, second stage
  logic              req_seen;      // Last request toggle served
  icp_req_t          cap;           // Captured request
  logic              rsp_tgl;       // Response toggle to link
  logic [MEM_DW-1:0] rsp_data;      // Read word to link
  icp_lstat_t        stat;          // Status toward link
  logic              mem_we;
  logic [MEM_AW-1:0] mem_addr;
  logic [MEM_DW-1:0] mem_wdata;
  logic [MEM_DW-1:0] mem_rdata;

  // Link-domain signals read by the core
  icp_req_t          req_word;      // Held stable until answered
  logic              req_tgl;       // Flips once per request

  // Core decode
  wire req_new   = (req_s2 != req_seen) && (cst == C_RUN);
  wire wr_r12    = (cap.addr == UNLOCK_REG);
  wire wr_upper  = (cap.addr >= UPPER_FIRST);
  wire write_ok  = cap.we && !is_read_only(cap.addr) && (!wr_upper || unlocked);  // [RQ14] [RQ17]
  wire [MEM_DW-1:0] merged = (wr_r12 && !unlocked) ? {mem_rdata[15:8], cap.wdata[7:0]}
                                                    : cap.wdata;                  // [RQ14]
  wire in_clear  = (cst == C_CLEAR);
  wire in_fo     = (cst == C_FUSE_OUT);
  wire in_fs     = (cst == C_FUSE_SSC);

  // Memory port selection
  assign mem_we    = in_clear || in_fo || in_fs || ((cst == C_APPLY) && write_ok);
  assign mem_addr  = in_clear ? clr_addr : in_fo ? FUSE_OUT_REG : in_fs ? FUSE_SSC_REG :
                     req_new ? req_word.addr : cap.addr;
  assign mem_wdata = in_clear ? REG_RESET : in_fo ? FUSE_OUT_CFG[page] :            // [RQ16]
                     in_fs ? FUSE_SSC_CFG[page] : merged;

  // Strap pin synchroniser
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pin_s1 <= 5'h00;
      pin_s2 <= 5'h00;
    end else begin
      pin_s1 <= {i_ref_ctrl, i_addr_strap, i_fuse_page};
      pin_s2 <= pin_s1;
    end
  end

  // Request toggle synchroniser
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
    end else begin
      req_s1 <= req_tgl;
      req_s2 <= req_s1;
    end
  end

  // Core sequencer: straps, clear, fuse load, then serve requests
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cst       <= C_STRAP;
      strap_cnt <= 2'h0;
      bus_mode  <= 1'b0;
      own_lsbs  <= 2'h0;
      page      <= 2'h0;
      unlocked  <= 1'b0;
      clr_addr  <= '0;
      req_seen  <= 1'b0;
      cap       <= '0;
      rsp_tgl   <= 1'b0;
      rsp_data  <= REG_RESET;
    end else begin
      case (cst)
        C_STRAP: begin
          // Wait for synchronised straps before catching them
          strap_cnt <= strap_cnt + 2'h1;
          if (strap_cnt == STRAP_WAIT) begin
            bus_mode <= !pin_s2[4];                                 // [RQ18]
            own_lsbs <= strap_lsbs(pin_s2[3:2]);                    // [RQ4]
            page     <= pin_s2[4] ? pin_s2[1:0] : BUS_MODE_PAGE;    // [RQ16]
            cst      <= C_CLEAR;
          end
        end
        C_CLEAR: begin
          // Sweep gives every register its defined value
          clr_addr <= clr_addr + 8'h01;
          if (clr_addr == MEM_LAST) begin
            cst <= C_FUSE_OUT;
          end
        end
        C_FUSE_OUT: cst <= C_FUSE_SSC;
        C_FUSE_SSC: cst <= C_RUN;
        C_RUN: begin
          // Request word is stable while its toggle is unanswered
          if (req_new) begin
            req_seen <= req_s2;
            cap      <= req_word;
            cst      <= C_APPLY;
          end
        end
        C_APPLY: begin
          // Old word returned; lock follows the key byte
          rsp_data <= mem_rdata;
          rsp_tgl  <= !rsp_tgl;
          if (cap.we && wr_r12) begin
            unlocked <= (cap.wdata[7:0] == UNLOCK_KEY);             // [RQ14]
          end
          cst <= C_RUN;
        end
        default: cst <= C_STRAP;
      endcase
    end
  end

  // Status toward the link, changes only at start-up
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      stat <= '0;
    end else begin
      stat <= '{enable: bus_mode && ((cst == C_RUN) || (cst == C_APPLY)), lsbs: own_lsbs};
    end
  end

  icp_regmem u_regmem (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_we    (mem_we),
    .i_addr  (mem_addr),
    .i_wdata (mem_wdata),
    .o_rdata (mem_rdata)
  );

  assign o_bus_mode  = bus_mode;
  assign o_cfg_ready = stat.enable;
  assign o_unlocked  = unlocked;
  assign o_fuse_page = page;

  // Core checks
  property p_lock;
    @(posedge i_clk) disable iff (!i_rst_n)
    (cst == C_APPLY && cap.we && wr_upper && !unlocked) |-> !mem_we;
  endproperty
  a_lock: assert property (p_lock) else $error("upper space written while locked"); // [RQ14]

  property p_read_only;
    @(posedge i_clk) disable iff (!i_rst_n)
    (cst == C_APPLY && is_read_only(cap.addr)) |-> !mem_we;
  endproperty
  a_read_only: assert property (p_read_only) else $error("read-only register written"); // [RQ17]

  property p_fuse_load;
    @(posedge i_clk) disable iff (!i_rst_n)
    (cst == C_FUSE_OUT) |-> mem_we && (mem_addr == FUSE_OUT_REG) && (mem_wdata == FUSE_OUT_CFG[page])
      ##1 mem_we && (mem_addr == FUSE_SSC_REG) && (mem_wdata == FUSE_SSC_CFG[page]);
  endproperty
  a_fuse_load: assert property (p_fuse_load) else $error("fuse words not loaded"); // [RQ16]

  property p_standalone;
    @(posedge i_clk) disable iff (!i_rst_n)
    (cst == C_RUN && !bus_mode) |=> !stat.enable;
  endproperty
  a_standalone: assert property (p_standalone) else $error("port enabled in fuse mode"); // [RQ18]

  // ---------------- Link domain ----------------
  typedef enum {L_IDLE, L_ADDR, L_ADDR_ACK, L_REG, L_REG_ACK, L_WR, L_WR_ACK, L_RD, L_RD_ACK, L_IGNORE}
    icp_lstate_t;

  logic              lrst_s1;       // Reset synchroniser, first stage
  logic              lrst_n;        // Reset for the link domain
  logic [1:0]        pin_m;         // Bus pin sync, first stage (0 clock, 1 data)
  logic [1:0]        pin_s;         // Bus pin sync, second stage
  logic [1:0]        filt;          // Filtered line levels
  logic [FILT_W-1:0] fcnt [2];      // Consecutive differing samples
  logic              scl_d;         // Filtered clock, last cycle
  logic              sda_d;         // Filtered data, last cycle
  icp_lstat_t        lstat_s1;
  icp_lstat_t        lstat;
  logic              rsp_s1;
  logic              rsp_s2;
  logic              rsp_seen;
  logic [MEM_DW-1:0] rdata_l;       // Latest read word
  icp_lstate_t       lst;
  logic [2:0]        bcnt;          // Bits in the current byte
  logic              full;          // Eight bits seen
  logic [7:0]        shreg;         // Byte shift register
  logic              rw;            // Read flag of the address byte
  logic [MEM_AW-1:0] reg_ptr;       // Register index, auto increments
  logic              byte_hi;       // Next data byte is the upper one
  logic [7:0]        hi_byte;       // Upper write byte held
  logic              acked;         // Controller acknowledged the read byte
  logic              sda_oe;        // Pulling the data line low

  // Link reset synchroniser, it may lag the core reset by two edges
  always_ff @(posedge i_link_clk) begin
    lrst_s1 <= i_rst_n;
    lrst_n  <= lrst_s1;
  end

  // Per-line synchroniser and glitch filter
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_line
      always_ff @(posedge i_link_clk) begin
        if (!lrst_n) begin
          pin_m[gi]  <= 1'b1;
          pin_s[gi]  <= 1'b1;
          filt[gi]   <= 1'b1;
          fcnt[gi]   <= '0;
        end else begin
          pin_m[gi] <= (gi == 0) ? i_scl : i_sda;                 // [RQ1]
          pin_s[gi] <= pin_m[gi];
          // New level taken only after it persists past the glitch time
          if (pin_s[gi] == filt[gi]) begin
            fcnt[gi] <= '0;
          end else if (fcnt[gi] == FILT_LIMIT) begin
            filt[gi] <= pin_s[gi];                                  // [RQ2]
            fcnt[gi] <= '0;
          end else begin
            fcnt[gi] <= fcnt[gi] + 1'b1;
          end
        end
      end
    end
  endgenerate

  // Status, response toggle and read word crossing
  always_ff @(posedge i_link_clk) begin
    if (!lrst_n) begin
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
      lstat_s1 <= '0;
      lstat    <= '0;
      rsp_s1   <= 1'b0;
      rsp_s2   <= 1'b0;
      rsp_seen <= 1'b0;
      rdata_l  <= REG_RESET;
    end else begin
      scl_d    <= filt[0];
      sda_d    <= filt[1];
      lstat_s1 <= stat;
      lstat    <= lstat_s1;
      rsp_s1   <= rsp_tgl;
      rsp_s2   <= rsp_s1;
      if (rsp_s2 != rsp_seen) begin
        rsp_seen <= rsp_s2;
        rdata_l  <= rsp_data;
      end
    end
  end

  // Bus event decode
  wire scl_rise = filt[0] && !scl_d;
  wire scl_fall = !filt[0] && scl_d;
  wire start    = filt[0] && scl_d && sda_d && !filt[1];           // [RQ6]
  wire stop     = filt[0] && scl_d && !sda_d && filt[1];           // [RQ6]
  wire rx_state = (lst == L_ADDR) || (lst == L_REG) || (lst == L_WR);
  wire match    = lstat.enable && (shreg[7:1] == {ADDR_UPPER, lstat.lsbs});  // [RQ3] [RQ4]
  wire [7:0] rd_byte = byte_hi ? rdata_l[15:8] : rdata_l[7:0];

  // Bus target sequencer; drive changes on clock falls, and a start or stop releases it
  always_ff @(posedge i_link_clk) begin
    if (!lrst_n) begin
      lst      <= L_IDLE;
      bcnt     <= 3'h0;
      full     <= 1'b0;
      shreg    <= 8'h00;
      rw       <= 1'b0;
      reg_ptr  <= '0;
      byte_hi  <= 1'b1;
      hi_byte  <= 8'h00;
      acked    <= 1'b0;
      sda_oe   <= 1'b0;
      req_word <= '0;
      req_tgl  <= 1'b0;
    end else if (start) begin
      lst    <= L_ADDR;                                             // [RQ6]
      bcnt   <= 3'h0;
      full   <= 1'b0;
      sda_oe <= 1'b0;
    end else if (stop) begin
      lst    <= L_IDLE;                                             // [RQ6] [RQ11] [RQ13]
      sda_oe <= 1'b0;
    end else if (scl_rise) begin
      if (rx_state) begin
        shreg <= {shreg[6:0], filt[1]};                             // [RQ7]
        bcnt  <= bcnt + 3'h1;
        full  <= (bcnt == 3'h7);
      end else if (lst == L_RD) begin
        bcnt <= bcnt + 3'h1;
        full <= (bcnt == 3'h7);
      end else if (lst == L_RD_ACK) begin
        acked <= !filt[1];
        if (filt[1]) begin
          lst <= L_IGNORE;                                          // [RQ12]
        end
      end
    end else if (scl_fall) begin
      case (lst)
        L_ADDR: if (full) begin
          full <= 1'b0;
          if (match) begin
            lst    <= L_ADDR_ACK;
            sda_oe <= 1'b1;                                         // [RQ9] [RQ10]
            rw     <= shreg[0];
            if (shreg[0]) begin
              req_word <= '{we: 1'b0, addr: reg_ptr, wdata: '0};
              req_tgl  <= !req_tgl;
              byte_hi  <= 1'b1;
            end
          end else begin
            lst <= L_IGNORE;                                        // [RQ10]
          end
        end
        L_ADDR_ACK: begin
          bcnt <= 3'h0;
          if (rw) begin
            lst    <= L_RD;
            shreg  <= rd_byte;
            sda_oe <= !rd_byte[7];                                  // [RQ7] [RQ5]
            byte_hi <= 1'b0;
          end else begin
            lst    <= L_REG;
            sda_oe <= 1'b0;                                         // [RQ19]
          end
        end
        L_REG: if (full) begin
          full    <= 1'b0;
          reg_ptr <= shreg;                                         // [RQ8]
          lst     <= L_REG_ACK;
          sda_oe  <= 1'b1;                                          // [RQ9]
        end
        L_WR: if (full) begin
          full   <= 1'b0;
          lst    <= L_WR_ACK;
          sda_oe <= 1'b1;                                           // [RQ9]
          if (byte_hi) begin
            hi_byte <= shreg;                                       // [RQ8]
            byte_hi <= 1'b0;
          end else begin
            req_word <= '{we: 1'b1, addr: reg_ptr, wdata: {hi_byte, shreg}};  // [RQ8]
            req_tgl  <= !req_tgl;
            reg_ptr  <= reg_ptr + 8'h01;
            byte_hi  <= 1'b1;
          end
        end
        L_REG_ACK, L_WR_ACK: begin
          lst     <= L_WR;
          bcnt    <= 3'h0;
          sda_oe  <= 1'b0;                                          // [RQ19]
          if (lst == L_REG_ACK) begin
            byte_hi <= 1'b1;
          end
        end
        L_RD: begin
          if (full) begin
            full   <= 1'b0;
            lst    <= L_RD_ACK;
            sda_oe <= 1'b0;                                         // [RQ19]
          end else begin
            shreg  <= {shreg[6:0], 1'b0};
            sda_oe <= !shreg[6];                                    // [RQ5] [RQ7]
          end
        end
        L_RD_ACK: if (acked) begin
          // Low byte leaves the word, so fetch the next one now
          lst    <= L_RD;
          bcnt   <= 3'h0;
          shreg  <= rd_byte;
          sda_oe <= !rd_byte[7];
          byte_hi <= !byte_hi;
          if (!byte_hi) begin
            reg_ptr  <= reg_ptr + 8'h01;
            req_word <= '{we: 1'b0, addr: reg_ptr + 8'h01, wdata: '0};
            req_tgl  <= !req_tgl;
          end
        end
        default: ;
      endcase
    end
  end

  // Open-drain data pin: output level is always low
  assign o_sda_o  = 1'b0;
  assign o_sda_oe = sda_oe;

  // Link checks
  property p_filter;
    @(posedge i_link_clk) disable iff (!lrst_n)
    (filt[0] != $past(filt[0])) |-> ($past(pin_s[0], 1) == filt[0]) && ($past(pin_s[0], 2) == filt[0]);
  endproperty
  a_filter: assert property (p_filter) else $error("clock edge taken from a short pulse"); // [RQ2]

  property p_match_ack;
    @(posedge i_link_clk) disable iff (!lrst_n)
    (lst == L_ADDR && full && scl_fall && !start && !stop && match) |=> sda_oe && (lst == L_ADDR_ACK);
  endproperty
  a_match_ack: assert property (p_match_ack) else $error("own address not acknowledged"); // [RQ3]

  property p_mismatch_idle;
    @(posedge i_link_clk) disable iff (!lrst_n)
    (lst == L_ADDR && full && scl_fall && !start && !stop && !match) |=> !sda_oe && (lst == L_IGNORE);
  endproperty
  a_mismatch_idle: assert property (p_mismatch_idle) else $error("foreign address answered"); // [RQ10]

  property p_stable_high;
    @(posedge i_link_clk) disable iff (!lrst_n)
    (filt[0] && scl_d && !start) |=> $stable(sda_oe) || stop;
  endproperty
  a_stable_high: assert property (p_stable_high) else $error("data drive changed while clock high"); // [RQ5]

  property p_nack_idle;
    @(posedge i_link_clk) disable iff (!lrst_n)
    (lst == L_RD_ACK && scl_rise && filt[1] && !start && !stop) |=> (lst == L_IGNORE) ##1 !sda_oe;
  endproperty
  a_nack_idle: assert property (p_nack_idle) else $error("read continued after not-acknowledge"); // [RQ12]

  property p_release;
    @(posedge i_link_clk) disable iff (!lrst_n)
    sda_oe |-> (lst inside {L_ADDR_ACK, L_REG_ACK, L_WR_ACK, L_RD});
  endproperty
  a_release: assert property (p_release) else $error("data line held outside ack or read"); // [RQ19]

  property p_stop_idle;
    @(posedge i_link_clk) disable iff (!lrst_n)
    (stop && !start) |=> (lst == L_IDLE) && !sda_oe;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop did not end the transfer"); // [RQ6]

endmodule
`default_nettype wire

//--- sim/icp_ctrl_model.sv
// Bus controller model: drives the bus clock and pulls the data line low
`timescale 1ns/1ps
`default_nettype none
module icp_ctrl_model #(
  parameter int HALF = 1250                         // Half bit period, fast mode
) (
  // Bus lines
  output logic      o_scl,
  output logic      o_sda_oe,
  input  wire logic i_sda
);
  localparam int HOLD = 300;                        // Data change after the clock falls
  initial begin
    o_scl    = 1'b1;
    o_sda_oe = 1'b0;
  end
  // Start or repeated start: data falls while clock high
  task automatic start();
    #(HOLD) o_sda_oe = 1'b0;
    #(HALF - HOLD) o_scl = 1'b1;
    #(HALF) o_sda_oe = 1'b1;
    #(HALF) o_scl = 1'b0;
  endtask
  // Stop: data low in clock low, rises while clock high
  task automatic stop();
    #(HOLD) o_sda_oe = 1'b1;
    #(HALF - HOLD) o_scl = 1'b1;
    #(HALF) o_sda_oe = 1'b0;
    #(HALF);
  endtask
  // Clock pulse shorter than the glitch time, while clock low
  task automatic glitch();
    #(HOLD) o_scl = 1'b1;
    #40 o_scl = 1'b0;
  endtask
  // One clock per bit, data moves only while clock low
  task automatic bit1(input logic b, output logic r);
    #(HOLD) o_sda_oe = ~b;
    #(HALF - HOLD) o_scl = 1'b1;
    #(HALF / 2) r = i_sda;
    #(HALF / 2) o_scl = 1'b0;
  endtask
  // Eight bits MSB first, then the acknowledge clock
  task automatic xb(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic ao);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit1(d[i], r);
      q[i] = r;
    end
    bit1(ai, ao);
  endtask
endmodule
`default_nettype wire

//--- sim/tb_top.sv
// Bench: configuration port driven by the bus controller model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import icp_pkg::*;
  logic       clk = 1'b0, lclk = 1'b0, rst_n = 1'b0, ref_c = 1'b0; // Clocks, reset, mode strap
  logic [1:0] strap = 2'h2, page = 2'h3;                           // Address strap, fuse page
  logic       scl, m_oe, d_o, d_oe, bmode, rdy, unl, a;            // Bus, status, ack seen
  logic [1:0] fpage;                                               // Page loaded
  logic [7:0] q;                                                   // Byte read back
  logic [6:0] dev = {ADDR_UPPER, 2'h2};                            // Own address for this strap
  wire logic  sda = !(m_oe || (d_oe && !d_o));                     // Pulled-up shared data line
  int         error_cnt = 0, comparisons = 0;
  initial forever #2.5 clk = ~clk;
  // Link clock offset so it never lines up with the core clock
  initial begin
    #3.3;
    forever #32 lclk = ~lclk;
  end
  icp_ctrl_model bus (.o_scl(scl), .o_sda_oe(m_oe), .i_sda(sda));
  icp_port dut (.i_clk(clk), .i_rst_n(rst_n), .i_link_clk(lclk), .i_scl(scl), .i_sda(sda),
    .o_sda_o(d_o), .o_sda_oe(d_oe), .i_ref_ctrl(ref_c), .i_addr_strap(strap), .i_fuse_page(page),
    .o_bus_mode(bmode), .o_cfg_ready(rdy), .o_unlocked(unl), .o_fuse_page(fpage));
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Reset long enough for the link side, then wait for start-up
  task automatic reset(input logic r);
    @(negedge clk) rst_n = 1'b0;
    ref_c = r;
    repeat (40) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 400 && rdy !== 1'b1; i++) @(negedge clk);
    #2000;
  endtask
  task automatic wb(input logic [7:0] d, input logic ea, input string nm);
    bus.xb(d, 1'b1, q, a);
    chk(nm, 16'(a), 16'(ea));
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d, input int nb);
    bus.start();
    wb({dev, 1'b0}, 1'b0, "addr_w");
    wb(idx, 1'b0, "index");
    for (int i = 0; i < nb; i++) wb(d[31-8*i -: 8], 1'b0, "data");
    bus.stop();
  endtask
  // Fuse mode keeps the bus port closed and loads the strapped page
  task automatic t_alone();
    reset(1'b1);
    chk("bus_mode", 16'(bmode), 16'h0);
    chk("cfg_ready", 16'(rdy), 16'h0);
    chk("fuse_page", 16'(fpage), 16'(page));
  endtask
  // Bus mode status, then a foreign address is ignored
  task automatic t_addr();
    reset(1'b0);
    chk("bus_mode", 16'(bmode), 16'h1);
    chk("cfg_ready", 16'(rdy), 16'h1);
    chk("sda_o", 16'(d_o), 16'h0);
    chk("fuse_page", 16'(fpage), 16'h0);
    bus.start();
    wb({dev ^ 7'h01, 1'b0}, 1'b1, "wrong_addr");
    bus.stop();
    chk("sda_oe", 16'(d_oe), 16'h0);
  endtask
  // Locked writes, key write, then a two-word read with final NACK
  task automatic t_lock();
    logic [31:0] rd;
    wr(8'h0c, 32'hab00_dead, 4);
    chk("locked", 16'(unl), 16'h0);
    wr(8'h0c, 32'hcd5b_0000, 2);
    chk("unlocked", 16'(unl), 16'h1);
    bus.start();
    // A counted glitch would shift the address by one bit and lose the ack
    bus.glitch();
    wb({dev, 1'b0}, 1'b0, "addr_w");
    wb(8'h0c, 1'b0, "index");
    bus.start();
    wb({dev, 1'b1}, 1'b0, "addr_r");
    for (int i = 0; i < 4; i++) begin
      bus.xb(8'hff, i == 3, q, a);
      rd[31-8*i -: 8] = q;
    end
    bus.stop();
    chk("reg12", rd[31:16], 16'h005b);
    chk("reg13", rd[15:0], 16'h0000);
    chk("sda_oe", 16'(d_oe), 16'h0);
  endtask
  initial begin
    t_alone();
    t_addr();
    t_lock();
    results();
  end
  // Cut a hang short some 50 us past the expected run time of about 450 us
  initial begin
    #500000;
    error_cnt++;
    results();
  end
endmodule
`default_nettype wire
